// File: core/nfcq_pkg.sv
// Package: constants, types and preset decode for the shared byte queue core
// Assumes one 50 MHz clock and plain control/status ports, no register bus
package nfcq_pkg;

  localparam int          NFCQ_DEPTH  = 64;
  localparam int          NFCQ_AW     = 6;
  localparam int          NFCQ_NFLAG  = 7;
  localparam logic [6:0]  NFCQ_FULL   = 7'h40;
  localparam logic [8:0]  NFCQ_LENCAP = 9'h100;
  localparam logic [15:0] NFCQ_POLY_M = 16'h1021;
  localparam logic [15:0] NFCQ_POLY_L = 16'h8408;
  localparam logic [3:0]  NFCQ_CMD_IDLE = 4'h0;
  localparam logic [15:0] NFCQ_CRC_RST  = 16'h0000;

  // Flag positions in primary_irq_reg and primary_irq_enable_reg
  localparam int NFCQ_F_TIMER = 0;
  localparam int NFCQ_F_ERR   = 1;
  localparam int NFCQ_F_AE    = 2;
  localparam int NFCQ_F_AF    = 3;
  localparam int NFCQ_F_CMD   = 4;
  localparam int NFCQ_F_RX    = 5;
  localparam int NFCQ_F_TX    = 6;

  typedef enum logic {NFCQ_CRC_IDLE, NFCQ_CRC_RUN} nfcq_crc_e;

  // Preset decode, shared by the core and its checks
  function automatic logic [15:0] nfcq_preset(input logic [1:0] sel);
    case (sel)
      2'h0:    nfcq_preset = 16'h0000;
      2'h1:    nfcq_preset = 16'h6363;
      2'h2:    nfcq_preset = 16'ha671;
      default: nfcq_preset = 16'hffff;
    endcase
  endfunction : nfcq_preset

endpackage : nfcq_pkg

// File: core/nfcq_crc_step.sv
// Combinational one-byte update of the 16-bit checksum
// Assumes the caller registers the result; no state here
`timescale 1ns/1ps
module nfcq_crc_step (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        high_bit_first,
  output logic      [15:0] crc_out
);
  import nfcq_pkg::*;

  // bit order: reflected register for low bit first
  always_comb begin
    logic [15:0] c;
    logic        b;
    c = crc_in;
    b = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (high_bit_first) begin
        b = data_in[7 - i] ^ c[15];
        c = {c[14:0], 1'b0} ^ (b ? NFCQ_POLY_M : 16'h0000);
      end else begin
        b = data_in[i] ^ c[0];
        c = {1'b0, c[15:1]} ^ (b ? NFCQ_POLY_L : 16'h0000);
      end
    end
    crc_out = c;
  end

endmodule : nfcq_crc_step

// File: core/nfcq_core.sv
// Shared 64-byte queue with length filter, checksum engine and event flags
// Assumes all inputs synchronous to core_clk; host and link logic are
// outside and see read data one cycle after the read strobe
`timescale 1ns/1ps
module nfcq_core (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // Host side of queue_data_reg
  input  wire logic                    host_wr,
  input  wire logic [7:0]              host_wr_data,
  input  wire logic                    host_rd,
  output logic      [7:0]              host_rd_data,
  input  wire logic                    queue_flush,
  // Core side: receiver writes, transmitter reads
  input  wire logic                    rx_valid,
  input  wire logic                    rx_first,
  input  wire logic [7:0]              rx_byte,
  input  wire logic                    core_rd,
  output logic      [7:0]              core_rd_data,
  // Configuration
  input  wire logic [5:0]              min_length_quads,
  input  wire logic [5:0]              max_length_quads,
  input  wire logic [5:0]              threshold_value,
  input  wire logic [1:0]              checksum_preset_sel,
  input  wire logic                    high_bit_first,
  input  wire logic                    crc_start,
  input  wire logic [6:0]              primary_irq_enable_reg,
  input  wire logic                    crc_irq_en,
  input  wire logic [6:0]              primary_irq_clr,
  input  wire logic                    secondary_irq_clr,
  // Event sources
  input  wire logic                    timer_dec,
  input  wire logic                    timer_at_one,
  input  wire logic                    tx_eof_start,
  input  wire logic                    rx_stream_end,
  input  wire logic [3:0]              command_code,
  input  wire logic [7:0]              error_flags_reg,
  input  wire logic                    link_active,
  // Status
  output logic      [6:0]              queue_fill_count,
  output logic                         queue_overflow,
  output logic                         almost_full,
  output logic                         almost_empty,
  output logic      [7:0]              crc_result_hi,
  output logic      [7:0]              crc_result_lo,
  output logic                         checksum_ready,
  output logic      [6:0]              primary_irq_reg,
  output logic                         checksum_done_flag,
  output logic                         irq_pin
);
  import nfcq_pkg::*;

  typedef struct packed {
    logic [NFCQ_DEPTH-1:0][7:0] mem;
    logic [NFCQ_AW-1:0]         wr_ptr;
    logic [NFCQ_AW-1:0]         rd_ptr;
    logic [6:0]                 count;
    logic                       ovf;
    logic [7:0]                 host_rd;
    logic [7:0]                 core_rd;
    logic                       rx_keep;
    logic [15:0]                crc;
    nfcq_crc_e                  crc_st;
    logic                       crc_ready;
    logic [6:0]                 flags;
    logic                       crc_flag;
    logic                       af;
    logic                       ae;
    logic [3:0]                 cmd_prev;
    logic                       irq;
  } nfcq_state_s;

  nfcq_state_s state_q;
  nfcq_state_s state_d;

  logic [8:0]  len_min;
  logic [8:0]  len_max;
  logic        len_ok;
  logic [7:0]  rd_byte;
  logic [15:0] crc_nx;

  // Length window: lower bound inclusive, upper bound exclusive
  // minimum bound
  assign len_min = {1'b0, min_length_quads, 2'b00};
  // maximum bound, zero setting means 256
  assign len_max = (max_length_quads == 6'h00) ? NFCQ_LENCAP
                                               : {1'b0, max_length_quads, 2'b00};
  assign len_ok  = ({1'b0, rx_byte} >= len_min) && ({1'b0, rx_byte} < len_max);

  // Byte at the read pointer, seen by every reader
  assign rd_byte = state_q.mem[state_q.rd_ptr];

  // checksum step over the byte being consumed
  nfcq_crc_step u_crc_step (
    .crc_in         (state_q.crc),
    .data_in        (rd_byte),
    .high_bit_first (high_bit_first),
    .crc_out        (crc_nx)
  );

  // Next state. The receiver wins the single write port and the checksum
  // engine wins the read port, so a contending host access is dropped;
  // the host is expected not to touch the queue while a command runs.
  always_comb begin
    logic       rx_wr;
    logic       wr_req;
    logic [7:0] wr_byte;
    logic       crc_rd;
    logic       sel_core;
    logic       sel_host;
    logic       do_wr;
    logic       do_rd;
    logic       empty;
    logic       full;
    logic       af_now;
    logic       ae_now;
    logic [6:0] set;
    rx_wr    = 1'b0;
    wr_req   = 1'b0;
    wr_byte  = 8'h00;
    crc_rd   = 1'b0;
    sel_core = 1'b0;
    sel_host = 1'b0;
    do_wr    = 1'b0;
    do_rd    = 1'b0;
    set      = 7'h00;
    state_d  = state_q;
    empty    = (state_q.count == 7'h00);
    full     = (state_q.count == NFCQ_FULL);

    // a rejected packet writes nothing until the next length byte
    if (rx_valid && rx_first) begin
      state_d.rx_keep = len_ok;
    end
    rx_wr   = rx_valid && (rx_first ? len_ok : state_q.rx_keep);
    wr_req  = rx_wr || host_wr;
    wr_byte = rx_wr ? rx_byte : host_wr_data;

    crc_rd   = (state_q.crc_st == NFCQ_CRC_RUN) && !empty && !queue_flush;
    sel_core = core_rd && !crc_rd;
    sel_host = host_rd && !crc_rd && !core_rd;

    // flush empties the queue and is the only overflow clear
    if (queue_flush) begin
      state_d.wr_ptr = '0;
      state_d.rd_ptr = '0;
      state_d.count  = 7'h00;
      state_d.ovf    = 1'b0;
    end else begin
      do_wr = wr_req && !full;
      do_rd = (crc_rd || sel_core || sel_host) && !empty;
      // Overflow: byte lost on a full queue
      if (wr_req && full) begin
        state_d.ovf = 1'b1;
      end
      if (do_wr) begin
        state_d.mem[state_q.wr_ptr] = wr_byte;
        state_d.wr_ptr = state_q.wr_ptr + 6'h01;
      end
      // read returns byte at read pointer and advances it
      if (do_rd) begin
        state_d.rd_ptr = state_q.rd_ptr + 6'h01;
      end
      if (sel_host && !empty) begin
        state_d.host_rd = rd_byte;
      end
      if (sel_core && !empty) begin
        state_d.core_rd = rd_byte;
      end
      state_d.count = state_q.count + {6'h00, do_wr} - {6'h00, do_rd};
    end

    // Checksum engine: start loads the preset, then drains the queue
    if (crc_start) begin
      state_d.crc       = nfcq_preset(checksum_preset_sel);
      state_d.crc_ready = 1'b0;
      state_d.crc_st    = NFCQ_CRC_RUN;
    end else if (state_q.crc_st == NFCQ_CRC_RUN) begin
      if (crc_rd) begin
        state_d.crc = crc_nx;
      end else if (empty) begin
        // ready and done flag once nothing is left
        state_d.crc_ready = 1'b1;
        state_d.crc_st    = NFCQ_CRC_IDLE;
      end
    end

    // alert levels from the current count
    af_now     = (NFCQ_FULL - state_q.count) <= {1'b0, threshold_value};
    ae_now     = state_q.count <= {1'b0, threshold_value};
    state_d.af = af_now;
    state_d.ae = ae_now;

    // Event sources; alerts flag on the rising edge only
    set[NFCQ_F_AF]    = af_now && !state_q.af;
    set[NFCQ_F_AE]    = ae_now && !state_q.ae;
    set[NFCQ_F_TIMER] = timer_dec && timer_at_one;
    set[NFCQ_F_TX]    = tx_eof_start;
    set[NFCQ_F_RX]    = rx_stream_end;
    set[NFCQ_F_CMD]   = (command_code == NFCQ_CMD_IDLE)
                        && (state_q.cmd_prev != NFCQ_CMD_IDLE);
    // any error bit while sending or receiving
    set[NFCQ_F_ERR]   = link_active && (error_flags_reg != 8'h00);
    state_d.cmd_prev  = command_code;

    // Set wins over clear so no event is lost in the clearing cycle
    state_d.flags    = (state_q.flags & ~primary_irq_clr) | set;
    state_d.crc_flag = (state_q.crc_flag && !secondary_irq_clr)
                       || ((state_q.crc_st == NFCQ_CRC_RUN) && !crc_start
                           && !crc_rd && empty);
    state_d.irq = |(state_d.flags & primary_irq_enable_reg)
                  || (state_d.crc_flag && crc_irq_en);
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q          <= '0;
      state_q.crc      <= NFCQ_CRC_RST;
      state_q.crc_st   <= NFCQ_CRC_IDLE;
      state_q.cmd_prev <= NFCQ_CMD_IDLE;
      state_q.ae       <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // All outputs come straight from the state register
  assign host_rd_data       = state_q.host_rd;
  assign core_rd_data       = state_q.core_rd;
  assign queue_fill_count   = state_q.count;
  assign queue_overflow     = state_q.ovf;
  assign almost_full        = state_q.af;
  assign almost_empty       = state_q.ae;
  assign crc_result_hi      = state_q.crc[15:8];
  assign crc_result_lo      = state_q.crc[7:0];
  assign checksum_ready     = state_q.crc_ready;
  assign primary_irq_reg    = state_q.flags;
  assign checksum_done_flag = state_q.crc_flag;
  assign irq_pin            = state_q.irq;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  len_min_a: assert property (
    rx_valid && rx_first && ({1'b0, rx_byte} < len_min) |=> !state_q.rx_keep)
    else $error("short packet accepted");

  len_max_a: assert property (
    rx_valid && rx_first && ({1'b0, rx_byte} >= len_max) |=> !state_q.rx_keep)
    else $error("long packet accepted");

  drop_pkt_a: assert property (
    !state_q.rx_keep && rx_valid && !rx_first && !host_wr
    |=> queue_fill_count <= $past(queue_fill_count))
    else $error("rejected packet byte stored");

  preset_load_a: assert property (
    crc_start |=> {crc_result_hi, crc_result_lo} == nfcq_preset($past(checksum_preset_sel)))
    else $error("wrong checksum preset");

  crc_done_a: assert property (
    (state_q.crc_st == NFCQ_CRC_RUN) && !crc_start && queue_fill_count == 7'h00
    && !rx_valid && !host_wr |=> checksum_ready && checksum_done_flag)
    else $error("checksum ready missing");

  host_write_a: assert property (
    host_wr && !rx_valid && !host_rd && !core_rd && !queue_flush
    && state_q.crc_st == NFCQ_CRC_IDLE && queue_fill_count < NFCQ_FULL
    |=> queue_fill_count == $past(queue_fill_count) + 7'h01)
    else $error("host write not counted");

  host_read_a: assert property (
    host_rd && !host_wr && !rx_valid && !core_rd && !queue_flush
    && state_q.crc_st == NFCQ_CRC_IDLE && queue_fill_count != 7'h00
    |=> queue_fill_count == $past(queue_fill_count) - 7'h01
        && host_rd_data == $past(rd_byte))
    else $error("host read wrong");

  flush_clr_a: assert property (
    queue_flush |=> queue_fill_count == 7'h00 && !queue_overflow)
    else $error("flush incomplete");

  ovf_hold_a: assert property (
    queue_overflow && !queue_flush |=> queue_overflow)
    else $error("overflow lost without flush");

  fill_bound_a: assert property (
    queue_fill_count <= NFCQ_FULL)
    else $error("fill count beyond capacity");

  full_alert_a: assert property (
    ##1 almost_full == ((NFCQ_FULL - $past(queue_fill_count))
                        <= {1'b0, $past(threshold_value)}))
    else $error("almost full wrong");

  empty_alert_a: assert property (
    ##1 almost_empty == ($past(queue_fill_count) <= {1'b0, $past(threshold_value)}))
    else $error("almost empty wrong");

  // The pin was computed with the enable of the cycle before the flag rose
  alert_flag_a: assert property (
    almost_full && !$past(almost_full) |-> primary_irq_reg[NFCQ_F_AF]
      && (irq_pin || !$past(primary_irq_enable_reg[NFCQ_F_AF])))
    else $error("alert flag missing");

  empty_flag_a: assert property (
    almost_empty && !$past(almost_empty) |-> primary_irq_reg[NFCQ_F_AE]
      && (irq_pin || !$past(primary_irq_enable_reg[NFCQ_F_AE])))
    else $error("empty alert flag missing");

  timer_flag_a: assert property (
    timer_dec && timer_at_one |=> primary_irq_reg[NFCQ_F_TIMER])
    else $error("timer flag missing");

  tx_flag_a: assert property (
    tx_eof_start |=> primary_irq_reg[NFCQ_F_TX])
    else $error("transmit flag missing");

  rx_flag_a: assert property (
    rx_stream_end |=> primary_irq_reg[NFCQ_F_RX])
    else $error("receive flag missing");

  cmd_idle_a: assert property (
    command_code == NFCQ_CMD_IDLE && $past(command_code) != NFCQ_CMD_IDLE
    |=> primary_irq_reg[NFCQ_F_CMD])
    else $error("command flag missing");

  // error flag, even against a clear in the same cycle
  err_flag_a: assert property (
    link_active && (error_flags_reg != 8'h00) |=> primary_irq_reg[NFCQ_F_ERR])
    else $error("error flag missing");

  accept_c: cover property (rx_valid && rx_first && len_ok ##1 rx_valid);
  reject_c: cover property (rx_valid && rx_first && !len_ok);
  crc_run_c: cover property (crc_start ##[1:70] checksum_ready);
  ovf_c: cover property (queue_overflow ##[1:10] queue_flush);

endmodule : nfcq_core

// File: testbench/nfcq_host_model.sv
// Host-side partner: drives the queue data port and the flush bit
// Assumes the bench calls its tasks; strobes change on the falling edge
`timescale 1ns/1ps
module nfcq_host_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] command_code,
  output logic            host_wr,
  output logic [7:0]      host_wr_data,
  output logic            host_rd,
  output logic            queue_flush
);
  import nfcq_pkg::*;
  initial begin
    host_wr      = 1'b0;
    host_wr_data = 8'h00;
    host_rd      = 1'b0;
    queue_flush  = 1'b0;
  end
  task automatic idle_wait();
    @(negedge core_clk);
    while (command_code !== NFCQ_CMD_IDLE) @(negedge core_clk);
  endtask : idle_wait
  // One byte per strobe; stale data is inverted so it is never mistaken for valid
  task automatic put(input logic [7:0] b);
    idle_wait();
    host_wr      = 1'b1;
    host_wr_data = b;
    @(negedge core_clk);
    host_wr      = 1'b0;
    host_wr_data = ~b;
  endtask : put
  task automatic get();
    idle_wait();
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
  endtask : get
  task automatic flush();
    idle_wait();
    queue_flush = 1'b1;
    @(negedge core_clk);
    queue_flush = 1'b0;
  endtask : flush
endmodule : nfcq_host_model

// File: testbench/tb_top.sv
// Self-checking bench for the shared queue core
// Assumes the host model drives the data port; the bench drives all else
`timescale 1ns/1ps
`define chk(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  import nfcq_pkg::*;
  logic core_clk, rst_b, host_wr, host_rd, queue_flush, rx_valid, rx_first, high_bit_first;
  logic crc_start, crc_irq_en, secondary_irq_clr, timer_dec, timer_at_one, tx_eof_start;
  logic rx_stream_end, link_active, queue_overflow, almost_full, almost_empty, irq_pin;
  logic checksum_ready, checksum_done_flag, rd_p, rdy_p, core_rd, crd_p;
  logic [7:0]  host_wr_data, host_rd_data, rx_byte, error_flags_reg, crc_result_hi;
  logic [7:0]  crc_result_lo, b, m8, core_rd_data;
  logic [5:0]  min_length_quads, max_length_quads, threshold_value;
  logic [1:0]  checksum_preset_sel;
  logic [3:0]  command_code;
  logic [6:0]  primary_irq_enable_reg, primary_irq_clr, queue_fill_count, primary_irq_reg;
  logic [15:0] c, m16;
  logic [7:0]  exp_q[$];
  logic [15:0] crc_q[$];
  int          error_cnt, checked, i, k, w, n;
  logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  // Filter cases: min, max, length byte
  logic [19:0] lf [6] = '{{6'd4, 6'd5, 8'd16}, {6'd4, 6'd5, 8'd15}, {6'd4, 6'd5, 8'd20},
                          {6'd4, 6'd5, 8'd19}, {6'd9, 6'd0, 8'd35}, {6'd9, 6'd0, 8'd255}};
  // Expected flags per event kind
  logic [6:0]  ev_m [7] = '{7'h01, 7'h00, 7'h02, 7'h00, 7'h20, 7'h40, 7'h10};

  nfcq_core nfcq_core_inst (.core_clk, .rst_b, .host_wr, .host_wr_data, .host_rd,
    .host_rd_data, .queue_flush, .rx_valid, .rx_first, .rx_byte, .core_rd,
    .core_rd_data, .min_length_quads, .max_length_quads, .threshold_value,
    .checksum_preset_sel, .high_bit_first, .crc_start, .primary_irq_enable_reg, .crc_irq_en,
    .primary_irq_clr, .secondary_irq_clr, .timer_dec, .timer_at_one, .tx_eof_start,
    .rx_stream_end, .command_code, .error_flags_reg, .link_active, .queue_fill_count,
    .queue_overflow, .almost_full, .almost_empty, .crc_result_hi, .crc_result_lo,
    .checksum_ready, .primary_irq_reg, .checksum_done_flag, .irq_pin);
  nfcq_host_model nfcq_host_model_inst (.core_clk, .command_code, .host_wr, .host_wr_data,
    .host_rd, .queue_flush);

  always #10 core_clk = ~core_clk;

  // bitwise reference, independent of the core's stepping logic
  function automatic logic [15:0] crc_ref(logic [15:0] cv, logic [7:0] d, logic msb);
    for (int j = 0; j < 8; j++) begin
      if (msb) cv = {cv[14:0], 1'b0} ^ ((cv[15] ^ d[7-j]) ? 16'h1021 : 16'h0000);
      else cv = {1'b0, cv[15:1]} ^ ((cv[0] ^ d[j]) ? 16'h8408 : 16'h0000);
    end
    return cv;
  endfunction : crc_ref

  task automatic rx_put(input logic [7:0] d, input logic f);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_first = f;
    rx_byte  = d;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_byte  = ~d;
  endtask : rx_put

  // One-cycle event pulse of the given kind
  task automatic fire(input int e);
    @(negedge core_clk);
    timer_dec       = (e < 2);
    timer_at_one    = (e == 0);
    error_flags_reg = (e == 2 || e == 3) ? 8'h01 << $urandom_range(0, 7) : 8'h00;
    link_active     = (e == 2);
    rx_stream_end   = (e == 4);
    tx_eof_start    = (e == 5);
    command_code    = (e == 6) ? 4'h3 : 4'h0;
    @(negedge core_clk);
    {timer_dec, timer_at_one, link_active, rx_stream_end, tx_eof_start} = '0;
    error_flags_reg = 8'h00;
    command_code    = 4'h0;
  endtask : fire

  task automatic summarize();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Scoreboard: read data and checksum results against the oldest note
  always @(posedge core_clk) {rd_p, crd_p} <= {host_rd, core_rd};
  always @(negedge core_clk) begin
    if (rd_p) begin
      m8 = exp_q.pop_front();
      `chk("rd_data", m8, host_rd_data)
    end
    if (crd_p) begin
      m8 = exp_q.pop_front();
      `chk("core_rd", m8, core_rd_data)
    end
    if (checksum_ready === 1'b1 && rdy_p === 1'b0) begin
      m16 = crc_q.pop_front();
      `chk("crc", m16, {crc_result_hi, crc_result_lo})
    end
    rdy_p <= checksum_ready;
  end

  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  initial begin
    core_clk = 1'b0;
    rst_b    = 1'b0;
    {rx_valid, rx_first, crc_start, crc_irq_en, secondary_irq_clr, core_rd} = '0;
    {timer_dec, timer_at_one, tx_eof_start, rx_stream_end, link_active, high_bit_first} = '0;
    {rx_byte, error_flags_reg, min_length_quads, max_length_quads, threshold_value} = '0;
    {checksum_preset_sel, command_code, primary_irq_enable_reg, primary_irq_clr} = '0;
    void'($urandom(32'hd07267c4));
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    `chk("fill", 7'h00, queue_fill_count)
    `chk("aempty", 1'b1, almost_empty)
    // Fill past capacity, watching both alerts against a random threshold
    threshold_value = 6'($urandom_range(1, 62));
    primary_irq_enable_reg = 7'h08;
    for (i = 0; i < 65; i++) begin
      b = 8'($urandom);
      nfcq_host_model_inst.put(b);
      if (i < 64) exp_q.push_back(b);
      `chk("fill", 7'(exp_q.size()), queue_fill_count)
      @(negedge core_clk);
      `chk("afull", 1'((64 - exp_q.size()) <= threshold_value), almost_full)
      `chk("aempty", 1'(exp_q.size() <= threshold_value), almost_empty)
    end
    `chk("ovf", 1'b1, queue_overflow)
    `chk("af_flag", 1'b1, primary_irq_reg[NFCQ_F_AF])
    `chk("irq", 1'b1, irq_pin)
    for (i = 0; i < 64; i++) nfcq_host_model_inst.get();
    @(negedge core_clk);
    `chk("fill", 7'h00, queue_fill_count)
    `chk("ae_flag", 1'b1, primary_irq_reg[NFCQ_F_AE])
    `chk("ovf", 1'b1, queue_overflow)
    nfcq_host_model_inst.flush();
    `chk("ovf", 1'b0, queue_overflow)
    // Length filter: rejected packets leave the receiver ready for the next
    n = 0;
    for (k = 0; k < 6; k++) begin
      {min_length_quads, max_length_quads, b} = lf[k];
      for (i = 0; i < 3; i++) rx_put(i == 0 ? b : 8'($urandom), i == 0);
      if (b >= 4 * min_length_quads && (max_length_quads == 0 || b < 4 * max_length_quads))
        n += 3;
      `chk("rx_fill", 7'(n), queue_fill_count)
    end
    nfcq_host_model_inst.flush();
    `chk("fill", 7'h00, queue_fill_count)
    // Transmitter side reads the same storage the host wrote
    for (i = 0; i < 2; i++) begin
      b = 8'($urandom);
      nfcq_host_model_inst.put(b);
      exp_q.push_back(b);
    end
    @(negedge core_clk);
    core_rd = 1'b1;
    @(negedge core_clk);
    core_rd = 1'b0;
    nfcq_host_model_inst.get();
    @(negedge core_clk);
    `chk("fill", 7'h00, queue_fill_count)
    // Checksum over every preset and both bit orders, plus empty runs
    crc_irq_en = 1'b1;
    primary_irq_enable_reg = 7'h00;
    for (k = 0; k < 12; k++) begin
      checksum_preset_sel = k[1:0];
      high_bit_first = k[2];
      c = pre[k[1:0]];
      for (i = 0; i < (k < 8 ? 3 : 0); i++) begin
        b = 8'($urandom);
        nfcq_host_model_inst.put(b);
        c = crc_ref(c, b, k[2]);
      end
      crc_q.push_back(c);
      @(negedge core_clk);
      crc_start = 1'b1;
      @(negedge core_clk);
      crc_start = 1'b0;
      for (w = 0; w < 50 && checksum_ready !== 1'b1; w++) @(negedge core_clk);
      @(negedge core_clk);
      `chk("crc_done", 1'b1, checksum_done_flag)
      `chk("crc_irq", 1'b1, irq_pin)
      secondary_irq_clr = 1'b1;
      @(negedge core_clk);
      secondary_irq_clr = 1'b0;
      `chk("crc_clr", 1'b0, checksum_done_flag)
    end
    // Event flags, with and without their qualifying conditions
    for (k = 0; k < 7; k++) begin
      primary_irq_enable_reg = 7'h00;
      @(negedge core_clk);
      primary_irq_clr = 7'h7f;
      @(negedge core_clk);
      primary_irq_clr = 7'h00;
      fire(k);
      repeat (2) @(negedge core_clk);
      `chk("flags", ev_m[k], primary_irq_reg)
      `chk("irq_off", 1'b0, irq_pin)
      primary_irq_enable_reg = ev_m[k];
      repeat (2) @(negedge core_clk);
      `chk("irq_on", |ev_m[k], irq_pin)
    end
    // A clear in the cycle of a new event loses to the event
    @(negedge core_clk);
    {timer_dec, timer_at_one, primary_irq_clr} = {2'b11, 7'h01};
    @(negedge core_clk);
    {timer_dec, timer_at_one, primary_irq_clr} = '0;
    @(negedge core_clk);
    `chk("set_wins", 1'b1, primary_irq_reg[NFCQ_F_TIMER])
    summarize();
  end
endmodule : tb_top
